// File: data_eeprom_erase_write_control.sv
// Purpose: erase and write control for a 256-word data eeprom behind AHB-Lite
// Assumes: one core clock; rst_b is power-on reset; reset pins arrive asynchronously
// Notes: bus stays responsive during operations; reads take wait states
// What this block does
// (RULE1) array occupies program addresses 7FFE00h through 7FFFFFh only
// (RULE2) array holds 256 words
// (RULE3) each location is a 16-bit word, individually read and written
// (RULE4) bus keeps serving transfers while an operation runs
// (RULE5) start needs key 55h then AAh written first
// (RULE6) unlock opens the control start for the next single transfer only
// (RULE7) start bit set by software, cleared only by hardware on completion; the code also clears it on a reset abort
// (RULE8) permit bit gates operations and is cleared when one finishes
// (RULE9) error flag set by reset abort, reads zero after success
// (RULE10) write erases target first unless skip-preerase is set
// (RULE11) erase-select picks erase when one, write when zero
// (RULE12) erase codes pick eight, four or one word
// (RULE13) erase code 0100xx erases the whole array
// (RULE14) write code 0001xx programs one word
// (RULE15) control bits 11..7 read zero; all control bits zero after reset
// (RULE16) software keeps interrupts off during the unlock sequence
// (RULE17) software waits two cycles after start, then polls start bit
// (RULE18) last table write address becomes the operation target
// (RULE19) undefined codes run as no operation, array untouched
// (RULE20) done flag set when an operation completes
// (RULE21) start outside the unlock window is ignored
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module data_eeprom_erase_write_control
  import eeprom_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // reset sources that abort an operation
  input wire logic master_clear_reset,
  input wire logic watchdog_reset,
  // completion flag
  output logic operation_done_irq_flag
);

  // ************************************************************
  // declarations
  // ************************************************************
  bus_state_type bus_state_reg;
  op_state_type op_state_reg;
  op_kind_type op_kind_reg;
  op_kind_type start_kind;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic hresp_reg;
  logic [7:0] dp_addr_reg;
  logic dp_hit_reg;
  logic dp_wr_reg;
  logic start_reg;
  logic permit_reg;
  logic err_reg;
  logic skip_reg;
  logic erase_sel_reg;
  logic [5:0] code_reg;
  logic got55_reg;
  logic window_reg;
  logic granted_reg;
  logic [23:0] tbl_ptr_reg;
  logic [23:0] target_reg;
  logic [15:0] data_latch_reg;
  logic [7:0] idx_reg;
  logic [8:0] left_reg;
  logic [11:0] timer_reg;
  logic done_flag_reg;
  logic master_clear_reset_s1_reg;
  logic master_clear_reset_s2_reg;
  logic wdt_s1_reg;
  logic wdt_s2_reg;
  logic accept;
  logic wr_now;
  logic ctl_wr;
  logic key_wr;
  logic key_aa;
  logic start_go;
  logic abort_now;
  logic done_now;
  logic busy;
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic mem_re;
  logic [15:0] mem_rdata;
  logic [31:0] rd_word;
  logic [7:0] tgt_idx;

  // ************************************************************
  // bus decode
  // ************************************************************
  assign accept = hsel && htrans[1] && hready;
  assign wr_now = dp_wr_reg && dp_hit_reg;
  assign ctl_wr = wr_now && (dp_addr_reg == OFS_CONTROL);
  assign key_wr = wr_now && (dp_addr_reg == OFS_KEY);
  assign key_aa = key_wr && got55_reg && (hwdata[7:0] == KEY_SECOND);
  assign busy = start_reg || (op_state_reg != ST_IDLE);
  assign abort_now = master_clear_reset_s2_reg || wdt_s2_reg;
  assign done_now = (op_state_reg == ST_WAIT) && (timer_reg == TIMER_LAST);
  assign start_kind = decode_op(hwdata[ERASE_BIT], hwdata[CODE_LSB +: CODE_W]);
  assign tgt_idx = word_index(target_reg);
  assign start_go = ctl_wr && !busy && granted_reg && hwdata[START_BIT]
    && hwdata[PERMIT_BIT] && !abort_now; // see (RULE5) see (RULE8) see (RULE21)

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;
  assign operation_done_irq_flag = done_flag_reg;

  // ************************************************************
  // reset pin synchronisers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      master_clear_reset_s1_reg <= 1'b0;
      master_clear_reset_s2_reg <= 1'b0;
      wdt_s1_reg <= 1'b0;
      wdt_s2_reg <= 1'b0;
    end else begin
      master_clear_reset_s1_reg <= master_clear_reset;
      master_clear_reset_s2_reg <= master_clear_reset_s1_reg;
      wdt_s1_reg <= watchdog_reset;
      wdt_s2_reg <= wdt_s1_reg;
    end
  end

  // ************************************************************
  // register read mux
  // ************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    if (dp_hit_reg) begin
      unique case (dp_addr_reg)
        OFS_CONTROL: rd_word = {16'h0000, start_reg, permit_reg, err_reg, skip_reg, 5'h00,
          erase_sel_reg, code_reg}; // see (RULE15)
        OFS_TBL_PTR: rd_word = {8'h00, tbl_ptr_reg};
        OFS_TARGET: rd_word = {8'h00, target_reg};
        OFS_STATUS: rd_word = {31'h0000_0000, done_flag_reg};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // ahb-lite data phase
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_reg <= BUS_IDLE;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
      hresp_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      dp_hit_reg <= 1'b0;
      dp_wr_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
      dp_wr_reg <= accept && hwrite;
      if (accept) begin
        dp_addr_reg <= haddr[7:0];
        dp_hit_reg <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
      end
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (accept && !hwrite) begin
            hreadyout_reg <= 1'b0;
            if ((haddr[31:8] == 24'h00_0000) && (haddr[7:0] == OFS_TBL_DATA)) begin
              bus_state_reg <= BUS_RD_MEM;
            end else begin
              bus_state_reg <= BUS_RD_REG;
            end
          end
        end
        BUS_RD_REG: begin
          hrdata_reg <= rd_word;
          hreadyout_reg <= 1'b1; // see (RULE4)
          bus_state_reg <= BUS_IDLE;
        end
        BUS_RD_MEM: begin
          bus_state_reg <= BUS_RD_MEM2;
        end
        BUS_RD_MEM2: begin
          hrdata_reg <= in_eeprom(tbl_ptr_reg) ? {16'h0000, mem_rdata} : 32'h0000_0000; // see (RULE3)
          hreadyout_reg <= 1'b1;
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // unlock sequence
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      got55_reg <= 1'b0;
      window_reg <= 1'b0;
      granted_reg <= 1'b0;
    end else begin
      if (key_wr) begin
        got55_reg <= (hwdata[7:0] == KEY_FIRST); // see (RULE5)
      end else if (wr_now || (bus_state_reg == BUS_RD_REG) || (bus_state_reg == BUS_RD_MEM2)) begin
        got55_reg <= 1'b0;
      end
      if (accept) begin
        granted_reg <= key_aa || window_reg; // see (RULE6)
        window_reg <= 1'b0;
      end else if (key_aa) begin
        window_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_reg <= CONTROL_RESET[START_BIT]; // see (RULE15)
      permit_reg <= CONTROL_RESET[PERMIT_BIT];
      err_reg <= CONTROL_RESET[ERR_BIT];
      skip_reg <= CONTROL_RESET[SKIP_BIT];
      erase_sel_reg <= CONTROL_RESET[ERASE_BIT];
      code_reg <= CONTROL_RESET[CODE_LSB +: CODE_W];
    end else if (abort_now) begin
      if (busy) begin
        err_reg <= 1'b1; // see (RULE9)
      end
      start_reg <= 1'b0;
    end else if (done_now) begin
      start_reg <= 1'b0; // see (RULE7)
      permit_reg <= 1'b0; // see (RULE8)
      err_reg <= 1'b0; // see (RULE9)
    end else if (ctl_wr && !busy) begin
      start_reg <= start_go; // see (RULE7) see (RULE21)
      permit_reg <= hwdata[PERMIT_BIT];
      err_reg <= hwdata[ERR_BIT];
      skip_reg <= hwdata[SKIP_BIT];
      erase_sel_reg <= hwdata[ERASE_BIT]; // see (RULE11)
      code_reg <= hwdata[CODE_LSB +: CODE_W];
    end
  end

  // ************************************************************
  // table pointer, target latch and data latch
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tbl_ptr_reg <= 24'h00_0000;
      target_reg <= 24'h00_0000;
      data_latch_reg <= 16'h0000;
    end else if (wr_now && !busy) begin
      if (dp_addr_reg == OFS_TBL_PTR) begin
        tbl_ptr_reg <= {1'b0, hwdata[22:1], 1'b0};
      end
      if (dp_addr_reg == OFS_TBL_DATA) begin
        target_reg <= tbl_ptr_reg; // see (RULE18)
        data_latch_reg <= hwdata[WORD_W-1:0];
      end
    end
  end

  // ************************************************************
  // operation sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_state_reg <= ST_IDLE;
      op_kind_reg <= OP_NONE;
      idx_reg <= 8'h00;
      left_reg <= 9'h000;
      timer_reg <= 12'h000;
    end else if (abort_now) begin
      op_state_reg <= ST_IDLE;
    end else begin
      unique case (op_state_reg)
        ST_IDLE: begin
          if (start_go) begin
            timer_reg <= OP_CYCLES_CNT;
            if (!in_eeprom(target_reg) && (start_kind != OP_BULK)) begin
              op_kind_reg <= OP_NONE; // see (RULE1)
              op_state_reg <= ST_WAIT;
            end else begin
              op_kind_reg <= start_kind;
              unique case (start_kind)
                OP_ERASE1: begin
                  idx_reg <= tgt_idx; // see (RULE12)
                  left_reg <= LEFT_ONE;
                  op_state_reg <= ST_ERASE;
                end
                OP_ERASE4: begin
                  idx_reg <= {tgt_idx[7:2], 2'b00}; // see (RULE12)
                  left_reg <= LEFT_FOUR;
                  op_state_reg <= ST_ERASE;
                end
                OP_ERASE8: begin
                  idx_reg <= {tgt_idx[7:3], 3'b000}; // see (RULE12)
                  left_reg <= LEFT_EIGHT;
                  op_state_reg <= ST_ERASE;
                end
                OP_BULK: begin
                  idx_reg <= 8'h00; // see (RULE13) see (RULE2)
                  left_reg <= LEFT_BULK;
                  op_state_reg <= ST_ERASE;
                end
                OP_WRITE: begin
                  idx_reg <= tgt_idx;
                  left_reg <= LEFT_ONE;
                  op_state_reg <= hwdata[SKIP_BIT] ? ST_PROG : ST_ERASE; // see (RULE10)
                end
                OP_NONE: begin
                  op_state_reg <= ST_WAIT; // see (RULE19)
                end
              endcase
            end
          end
        end
        ST_ERASE: begin
          idx_reg <= idx_reg + 8'h01;
          left_reg <= left_reg - 9'h001;
          if (left_reg == LEFT_ONE) begin
            op_state_reg <= (op_kind_reg == OP_WRITE) ? ST_PROG : ST_WAIT; // see (RULE10)
          end
        end
        ST_PROG: begin
          op_state_reg <= ST_WAIT; // see (RULE14)
        end
        ST_WAIT: begin
          timer_reg <= timer_reg - 12'h001;
          if (timer_reg == TIMER_LAST) begin
            op_state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // completion flag
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_flag_reg <= 1'b0;
    end else if (done_now && !abort_now) begin
      done_flag_reg <= 1'b1; // see (RULE20)
    end else if (wr_now && (dp_addr_reg == OFS_STATUS) && hwdata[DONE_BIT]) begin
      done_flag_reg <= 1'b0;
    end
  end

  // ************************************************************
  // array ports
  // ************************************************************
  assign mem_we = ((op_state_reg == ST_ERASE) || (op_state_reg == ST_PROG))
    && (op_kind_reg != OP_NONE); // see (RULE19)
  assign mem_waddr = (op_state_reg == ST_PROG) ? tgt_idx : idx_reg;
  assign mem_wdata = (op_state_reg == ST_PROG) ? data_latch_reg : ERASED_WORD; // see (RULE14)
  assign mem_re = (bus_state_reg == BUS_RD_MEM);

  eeprom_word_array u_array (
    .clk(clk),
    .rst_b(rst_b),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(word_index(tbl_ptr_reg)),
    .rdata(mem_rdata)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  a_start_needs_unlock: assert property ( // see (RULE5)
    @(posedge clk) disable iff (!rst_b)
    $rose(start_reg) |-> $past(granted_reg && ctl_wr))
    else $error("start bit rose without unlock grant");

  a_window_single_use: assert property ( // see (RULE6)
    @(posedge clk) disable iff (!rst_b)
    (accept && !key_aa && !window_reg) |=> !granted_reg)
    else $error("unlock grant outlived its transfer");

  a_start_has_permit: assert property ( // see (RULE8)
    @(posedge clk) disable iff (!rst_b)
    start_reg |-> permit_reg)
    else $error("start set while permit clear");

  a_done_clears_start: assert property ( // see (RULE7)
    @(posedge clk) disable iff (!rst_b)
    (done_now && !abort_now) |=> (!start_reg && !permit_reg && !err_reg && op_state_reg == ST_IDLE))
    else $error("completion did not clear start and permit");

  a_abort_sets_error: assert property ( // see (RULE9)
    @(posedge clk) disable iff (!rst_b)
    (abort_now && busy) |=> (err_reg && !start_reg && op_state_reg == ST_IDLE))
    else $error("abort did not flag error");

  a_erase_eight_len: assert property ( // see (RULE12)
    @(posedge clk) disable iff (!rst_b)
    (op_state_reg == ST_ERASE && $past(op_state_reg) == ST_IDLE && op_kind_reg == OP_ERASE8
      && !abort_now) |-> (op_state_reg == ST_ERASE && !abort_now)[*8] ##1 op_state_reg == ST_WAIT)
    else $error("eight word erase wrong length");

  a_bulk_erase_len: assert property ( // see (RULE13)
    @(posedge clk) disable iff (!rst_b || abort_now)
    (op_state_reg == ST_ERASE && $past(op_state_reg) == ST_IDLE && op_kind_reg == OP_BULK
      && mem_waddr == 8'h00) |-> ##255 (op_state_reg == ST_ERASE && mem_waddr == 8'hFF)
      ##1 op_state_reg == ST_WAIT)
    else $error("bulk erase wrong length");

  a_preerase_then_prog: assert property ( // see (RULE10)
    @(posedge clk) disable iff (!rst_b || abort_now)
    (op_state_reg == ST_ERASE && op_kind_reg == OP_WRITE) |-> (mem_wdata == ERASED_WORD)
      ##1 (op_state_reg == ST_PROG && mem_wdata == data_latch_reg && mem_we) ##1 op_state_reg == ST_WAIT)
    else $error("write did not erase then program");

  a_skip_no_erase: assert property ( // see (RULE10)
    @(posedge clk) disable iff (!rst_b)
    (op_state_reg == ST_PROG && $past(op_state_reg) == ST_IDLE) |-> skip_reg)
    else $error("preerase skipped without skip select");

  a_noop_untouched: assert property ( // see (RULE19)
    @(posedge clk) disable iff (!rst_b)
    (op_kind_reg == OP_NONE) |-> (!mem_we && op_state_reg inside {ST_IDLE, ST_WAIT}))
    else $error("no-operation code wrote the array");

  a_target_latched: assert property ( // see (RULE18)
    @(posedge clk) disable iff (!rst_b)
    (wr_now && !busy && dp_addr_reg == OFS_TBL_DATA) |=> target_reg == $past(tbl_ptr_reg))
    else $error("table write address not latched");

  a_done_flag_set: assert property ( // see (RULE20)
    @(posedge clk) disable iff (!rst_b)
    (done_now && !abort_now) |=> operation_done_irq_flag[*2])
    else $error("done flag missing after completion");

  a_reserved_zero: assert property ( // see (RULE15)
    @(posedge clk) disable iff (!rst_b)
    (bus_state_reg == BUS_RD_REG && dp_addr_reg == OFS_CONTROL) |=> hrdata_reg[11:7] == 5'h00)
    else $error("unimplemented control bits read nonzero");

  a_bus_not_stalled: assert property ( // see (RULE4)
    @(posedge clk) disable iff (!rst_b)
    !hreadyout_reg |-> ##[1:2] hreadyout_reg)
    else $error("bus held off too long");

endmodule : data_eeprom_erase_write_control

// File: data_eeprom_erase_write_control_test.sv
// Purpose: self-checking bench for the data eeprom erase and write control
// Assumes: AHB-Lite single word transfers on a 40 MHz clock
// Notes: every wait is bounded
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module data_eeprom_erase_write_control_test import eeprom_ctl_pkg::*;;
  // ********
  // signals
  // ********
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic master_clear_reset = 1'b0, watchdog_reset = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hc78e_446f;
  logic hready, hreadyout, hresp, operation_done_irq_flag;
  logic [31:0] hrdata, rd;
  logic [15:0] word;
  logic [7:0] idx;
  int fail_count = 0, samples_checked = 0;
  logic [31:0] ops [9] = '{32'h0000_4058, 32'h0000_5004, 32'h0000_4004, 32'h0000_4040,
    32'h0000_4059, 32'h0000_4004, 32'h0000_405A, 32'h0000_4004, 32'h0000_4050};
  assign hready = hreadyout;
  data_eeprom_erase_write_control dut_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .master_clear_reset,
    .watchdog_reset, .operation_done_irq_flag);
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ********
  // helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic logic [31:0] ea(input logic [7:0] i);
    return {8'h00, EEPROM_BASE + {15'h0000, i, 1'b0}};
  endfunction : ea
  function automatic logic [15:0] expect_word(input logic [31:0] c, input logic [15:0] old,
    input logic [15:0] nw);
    if (c[ERASE_BIT] && (c[5:0] inside {CODE_ERASE1, CODE_ERASE4, CODE_ERASE8}
      || c[5:2] == CODE_BULK_TOP)) return ERASED_WORD;
    if (!c[ERASE_BIT] && c[5:2] == CODE_WRITE_TOP) return nw;
    return old;
  endfunction : expect_word
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      if (++n > 40) begin
        fail_count++;
        conclude();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK("resp", 1'b0, hresp)
  endtask : xfer
  task automatic unlock;
    xfer(1'b1, OFS_KEY, 32'h0000_0055);
    xfer(1'b1, OFS_KEY, 32'h0000_00AA);
  endtask : unlock
  task automatic run_op(input logic [31:0] c, input logic [1:0] ab);
    xfer(1'b1, OFS_CONTROL, c);
    unlock();
    xfer(1'b1, OFS_CONTROL, c | 32'h0000_8000);
    {watchdog_reset, master_clear_reset} <= ab;
    xfer(1'b0, OFS_CONTROL, 32'h0);
    `CHK("start", 1'b1, rd[15])
    for (int n = 0; rd[15] === 1'b1; n++) begin
      if (n > 3000) begin
        fail_count++;
        conclude();
      end
      xfer(1'b0, OFS_CONTROL, 32'h0);
    end
    {watchdog_reset, master_clear_reset} <= 2'b00;
  endtask : run_op
  // ********
  // sequence
  // ********
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    xfer(1'b0, OFS_CONTROL, 32'h0);
    `CHK("ctl reset", 32'h0, rd)
    xfer(1'b1, OFS_CONTROL, 32'h0000_FFFF);
    xfer(1'b0, OFS_CONTROL, 32'h0);
    `CHK("ctl bits", 32'h0000_707F, rd)
    unlock();
    xfer(1'b1, OFS_CONTROL, 32'h0000_8004);
    xfer(1'b0, OFS_CONTROL, 32'h0);
    `CHK("no permit", 1'b0, rd[15])
    unlock();
    xfer(1'b0, OFS_TARGET, 32'h0);
    xfer(1'b1, OFS_CONTROL, 32'h0000_C004);
    xfer(1'b0, OFS_CONTROL, 32'h0);
    `CHK("window", 1'b0, rd[15])
    seed = xs(seed);
    idx = seed[7:0];
    word = 16'hFFFF;
    xfer(1'b1, OFS_TBL_PTR, ea(idx));
    foreach (ops[k]) begin
      seed = xs(seed);
      xfer(1'b1, OFS_TBL_DATA, {16'h0000, seed[15:0]});
      xfer(1'b0, OFS_TARGET, 32'h0);
      `CHK("target", ea(idx), rd)
      run_op(ops[k], 2'b00);
      `CHK("flags", 3'b000, rd[15:13])
      `CHK("done", 1'b1, operation_done_irq_flag)
      xfer(1'b1, OFS_STATUS, 32'h1);
      xfer(1'b0, OFS_STATUS, 32'h0);
      `CHK("done clr", 32'h0, rd)
      word = expect_word(ops[k], word, seed[15:0]);
      xfer(1'b0, OFS_TBL_DATA, 32'h0);
      `CHK("word", {16'h0000, word}, rd)
    end
    for (int a = 1; a < 3; a++) begin
      run_op(32'h0000_4004, 2'(a));
      `CHK("abort", 2'b01, {rd[15], rd[13]})
    end
    conclude();
  end
endmodule : data_eeprom_erase_write_control_test

// File: eeprom_ctl_pkg.sv
// Purpose: shared constants, types and helpers for the data eeprom controller
// Assumes: 40 MHz core clock, AHB-Lite register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package eeprom_ctl_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_TBL_PTR = 8'h08;
  localparam logic [7:0] OFS_TBL_DATA = 8'h0C;
  localparam logic [7:0] OFS_TARGET = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int START_BIT = 15;
  localparam int PERMIT_BIT = 14;
  localparam int ERR_BIT = 13;
  localparam int SKIP_BIT = 12;
  localparam int ERASE_BIT = 6;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 6;
  localparam int DONE_BIT = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // ************************************************************
  // unlock keys and operation codes
  // ************************************************************
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [5:0] CODE_ERASE8 = 6'h1A;
  localparam logic [5:0] CODE_ERASE4 = 6'h19;
  localparam logic [5:0] CODE_ERASE1 = 6'h18;
  localparam logic [3:0] CODE_BULK_TOP = 4'h4;
  localparam logic [3:0] CODE_WRITE_TOP = 4'h1;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam logic [23:0] EEPROM_BASE = 24'h7F_FE00;
  localparam logic [23:0] EEPROM_TOP = 24'h7F_FFFF;
  localparam int EEPROM_WORDS = 256;
  localparam int WORD_W = 16;
  localparam int INDEX_W = 8;
  localparam int EA_W = 24;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [8:0] LEFT_BULK = 9'h100;
  localparam logic [8:0] LEFT_EIGHT = 9'h008;
  localparam logic [8:0] LEFT_FOUR = 9'h004;
  localparam logic [8:0] LEFT_ONE = 9'h001;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int OP_TIME_NS = 100000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] OP_CYCLES_CNT = 12'(OP_CYCLES);
  localparam logic [11:0] TIMER_LAST = 12'h001;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {OP_NONE, OP_ERASE1, OP_ERASE4, OP_ERASE8, OP_BULK, OP_WRITE}
    op_kind_type;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} op_state_type;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD_REG, BUS_RD_MEM, BUS_RD_MEM2} bus_state_type;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic op_kind_type decode_op(input logic erase, input logic [5:0] code);
    op_kind_type k;
    k = OP_NONE;
    if (erase) begin
      if (code == CODE_ERASE8) k = OP_ERASE8;
      else if (code == CODE_ERASE4) k = OP_ERASE4;
      else if (code == CODE_ERASE1) k = OP_ERASE1;
      else if (code[5:2] == CODE_BULK_TOP) k = OP_BULK;
    end else if (code[5:2] == CODE_WRITE_TOP) begin
      k = OP_WRITE;
    end
    return k;
  endfunction : decode_op

  function automatic logic in_eeprom(input logic [23:0] ea);
    return (ea >= EEPROM_BASE) && (ea <= EEPROM_TOP);
  endfunction : in_eeprom

  function automatic logic [7:0] word_index(input logic [23:0] ea);
    return ea[8:1];
  endfunction : word_index

endpackage : eeprom_ctl_pkg

// File: eeprom_word_array.sv
// Purpose: 256 x 16 data eeprom cell array
// Assumes: one write port and one read port on the core clock
// Notes: read data come out of a register one cycle after re
`timescale 1ns/1ps
module eeprom_word_array
  import eeprom_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [15:0] wdata,
  // read port
  input wire logic re,
  input wire logic [7:0] raddr,
  output logic [15:0] rdata
);

  logic [WORD_W-1:0] cells [EEPROM_WORDS];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (re) begin
      rdata <= cells[raddr];
    end
  end

endmodule : eeprom_word_array
